// ### design/dc_feed_param_map.vh
`ifndef DC_FEED_PARAM_MAP_VH
`define DC_FEED_PARAM_MAP_VH
// Word addresses of the parameter bank
`define ADDR_OPEN_CIRCUIT     8'h00
`define ADDR_OFFHOOK_OFFSET   8'h01
`define ADDR_OFFSET_UPPER     8'h03
`define ADDR_COMMON_MODE      8'h04
`define ADDR_LOOP_VOLTAGE     8'h07
`define ADDR_BATTERY_VOLTAGE  8'h0D
`define ADDR_RING_SETTLE      8'hA9
// Reset values
`define RST_WORD              16'h0000
// Field layout of the 15-bit settings
`define SET_MSB               14
// Settling timer scaling
`define SETTLE_TICK_US        1250
`define SETTLE_DEFAULT_MS     60
`define SETTLE_DEFAULT_COUNT  16'h0030
`endif

// ### design/settle_tick_div.v
`timescale 1ns/1ps
`default_nettype none
// Divides the system clock to a one-cycle tick enable
module settle_tick_div #(
  parameter DIV = 12500
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Tick enable out
  output reg         tick
);
  reg [15:0] cnt_reg;  // Cycle counter

  // Counter wraps at DIV-1 and fires one pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b0;
    end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick    <= 1'b0;
    end
  end
endmodule // settle_tick_div
`default_nettype wire

// ### design/dc_feed_param_ram.v
`timescale 1ns/1ps
`default_nettype none
`include "dc_feed_param_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Leaving ringing state starts settling timer
// - Timer counts 1.25 ms per LSB
// - Zero timer word means 60 ms
// - Battery word refreshed from monitor converter
// - Loop word refreshed from each measured loop voltage sample
// - Common-mode target follows polarity lead
// - Open-circuit word is on-hook target
// - Off-hook adds offset to open-circuit target
// - Reset clears measurement and setting words
// - Offset removed above upper delta going on-hook
module dc_feed_param_ram #(
  parameter CLK_HZ = 10000000,
  parameter TICK_CYCLES = (CLK_HZ / 1000) * `SETTLE_TICK_US / 1000
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Word access from the serial control port
  input  wire [7:0]  addr,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  input  wire        rd_en,
  output reg  [15:0] rd_data,
  output wire        rd_hit,
  // Line state from the feed controller
  input  wire        ringing,
  input  wire        off_hook,
  input  wire        reverse_pol,
  // Monitor converter samples
  input  wire        bat_valid,
  input  wire [15:0] bat_sample,
  input  wire        loop_valid,
  input  wire [15:0] loop_sample,
  // Feed targets out
  output reg  [15:0] ocv_target,
  output reg  [14:0] tip_cm_target,
  output reg  [14:0] ring_cm_target,
  output reg         speedup
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage
  // The 15-bit settings keep no bit 15 at all, so a read
  // returns it as zero without extra masking logic.
  // Sense words are host-writable but hardware-owned.
  reg [14:0] open_circuit_voltage_reg;      // On-hook target
  reg [14:0] offhook_offset_voltage_reg;    // Off-hook offset
  reg [15:0] offset_removal_upper_delta_reg;// Removal threshold delta
  reg [14:0] common_mode_voltage_reg;       // Common-mode setting
  reg [15:0] loop_voltage_sense_reg;        // Measured loop voltage
  reg [15:0] battery_voltage_sense_reg;     // Measured battery
  reg [15:0] ringing_settle_timer_reg;      // Settling interval word
  reg [15:0] settle_cnt_reg;                // Running down-count
  reg        ringing_d_reg;                 // Ringing delayed
  reg        offset_on_reg;                 // Offset currently applied
  reg        off_hook_d_reg;                // Hook delayed
  wire       tick;                          // 1.25 ms enable
  wire [15:0] settle_load;                  // Interval in ticks

  // Reload value with zero mapped to default; zero never means
  // an instant expiry, which would defeat the settling speedup
  function [15:0] settle_len;
    input [15:0] w;
    begin
      settle_len = (w == 16'h0000) ? `SETTLE_DEFAULT_COUNT : w;
    end
  endfunction

  // Zero-extends a 15-bit setting to the word width
  function [15:0] widen_set;
    input [14:0] w;
    begin
      widen_set = {1'b0, w};
    end
  endfunction

  // Interval reloaded at every ringing exit
  assign settle_load = settle_len(ringing_settle_timer_reg);
  // Mapped-address flag, combinational so the control port
  // knows in the request cycle whether data will follow
  assign rd_hit = (addr == `ADDR_OPEN_CIRCUIT) || (addr == `ADDR_OFFHOOK_OFFSET) ||
                  (addr == `ADDR_OFFSET_UPPER) || (addr == `ADDR_COMMON_MODE) ||
                  (addr == `ADDR_LOOP_VOLTAGE) || (addr == `ADDR_BATTERY_VOLTAGE) ||
                  (addr == `ADDR_RING_SETTLE);

  // Tick divider, 1.25 ms at 10 MHz
  // It runs free from reset, so the first tick after a ringing
  // exit lands anywhere within one tick period: the interval
  // comes out short by up to one tick, never long
  settle_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_div (
    .clk  (clk),
    .rst_n(rst_n),
    .tick (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; hardware samples win over host writes
  // Bit 15 of a 15-bit setting is dropped on write. A host
  // write to a sense word is legal but lasts only until the
  // next converter sample
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open_circuit_voltage_reg       <= 15'h0000;
      offhook_offset_voltage_reg     <= 15'h0000;
      common_mode_voltage_reg        <= 15'h0000;
      battery_voltage_sense_reg      <= `RST_WORD;
      offset_removal_upper_delta_reg <= `RST_WORD;
      loop_voltage_sense_reg         <= `RST_WORD;
      ringing_settle_timer_reg       <= `RST_WORD;
    end else begin
      if (wr_en) begin
        case (addr)
          `ADDR_OPEN_CIRCUIT:    open_circuit_voltage_reg <= wr_data[`SET_MSB:0];
          `ADDR_OFFHOOK_OFFSET:  offhook_offset_voltage_reg <= wr_data[`SET_MSB:0];
          `ADDR_OFFSET_UPPER:    offset_removal_upper_delta_reg <= wr_data;
          `ADDR_COMMON_MODE:     common_mode_voltage_reg <= wr_data[`SET_MSB:0];
          `ADDR_LOOP_VOLTAGE:    loop_voltage_sense_reg <= wr_data;
          `ADDR_BATTERY_VOLTAGE: battery_voltage_sense_reg <= wr_data;
          `ADDR_RING_SETTLE:     ringing_settle_timer_reg <= wr_data;
          default: ;
        endcase
      end
      // Converter update overrides a same-cycle write
      if (bat_valid)
        battery_voltage_sense_reg <= bat_sample;
      if (loop_valid)
        loop_voltage_sense_reg <= loop_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, registered; unmapped reads zero
  // Data stands until the next read request, so the port may
  // take it at any time after the answer cycle; a read costs
  // one clock of latency in exchange for a clean output
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      case (addr)
        `ADDR_OPEN_CIRCUIT:    rd_data <= widen_set(open_circuit_voltage_reg);
        `ADDR_OFFHOOK_OFFSET:  rd_data <= widen_set(offhook_offset_voltage_reg);
        `ADDR_OFFSET_UPPER:    rd_data <= offset_removal_upper_delta_reg;
        `ADDR_COMMON_MODE:     rd_data <= widen_set(common_mode_voltage_reg);
        `ADDR_LOOP_VOLTAGE:    rd_data <= loop_voltage_sense_reg;
        `ADDR_BATTERY_VOLTAGE: rd_data <= battery_voltage_sense_reg;
        `ADDR_RING_SETTLE:     rd_data <= ringing_settle_timer_reg;
        default:               rd_data <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settling timer: start on any exit from ringing
  // The exit is seen in the cycle ringing first reads low, via the delayed copy;
  // a return to ringing while the count runs does not stop it,
  // the count simply reloads at the next exit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ringing_d_reg  <= 1'b0;
      settle_cnt_reg <= 16'h0000;
      speedup        <= 1'b0;
    end else begin
      ringing_d_reg <= ringing;
      // Load wins over a coincident tick so the full interval runs
      if (ringing_d_reg && !ringing)
        settle_cnt_reg <= settle_load;
      else if (tick && settle_cnt_reg != 16'h0000)
        settle_cnt_reg <= settle_cnt_reg - 16'h0001;
      // Speedup held while count runs
      speedup <= (ringing_d_reg && !ringing) || (settle_cnt_reg != 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Off-hook offset apply and removal with hysteresis
  // Offset goes on at the hook edge and stays on until the line
  // rises past open-circuit plus the removal delta while on-hook;
  // the gap keeps it from chattering near the boundary
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      off_hook_d_reg <= 1'b0;
      offset_on_reg  <= 1'b0;
    end else begin
      off_hook_d_reg <= off_hook;
      if (off_hook && !off_hook_d_reg)
        offset_on_reg <= 1'b1;
      // Sum taken one bit wider so the threshold cannot wrap
      else if (!off_hook && offset_on_reg &&
               ({1'b0, loop_voltage_sense_reg} >
                {2'b00, open_circuit_voltage_reg} + {1'b0, offset_removal_upper_delta_reg}))
        offset_on_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feed targets registered from settings
  // Registered so the analog side sees glitch-free words;
  // each target lags its settings by one clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ocv_target     <= 16'h0000;
      tip_cm_target  <= 15'h0000;
      ring_cm_target <= 15'h0000;
    end else begin
      // Both parts are 15-bit, so the sum always fits the word
      ocv_target <= offset_on_reg ?
                    (widen_set(open_circuit_voltage_reg) + widen_set(offhook_offset_voltage_reg)) :
                    widen_set(open_circuit_voltage_reg);
      tip_cm_target  <= reverse_pol ? 15'h0000 : common_mode_voltage_reg;
      ring_cm_target <= reverse_pol ? common_mode_voltage_reg : 15'h0000;
    end
  end
endmodule // dc_feed_param_ram
`default_nettype wire

// ### sim/dc_feed_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the parameter bank
module dc_feed_monitor (
  input wire logic clk, rst_n, wr_en, rd_en, rd_hit, ringing, off_hook,
  input wire logic reverse_pol, bat_valid, loop_valid, speedup,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data, rd_data, bat_sample, loop_sample, ocv_target,
  input wire logic [14:0] tip_cm_target, ring_cm_target
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic quiet;  // No sample write that could beat the host
  assign quiet = !bat_valid && !loop_valid;
  // Sample pulse followed at once by a read of that word
  sequence s_sense(v, a);
    v && !wr_en ##1 rd_en && !v && !wr_en && addr == a;
  endsequence
  sequence s_pol(p);
    (reverse_pol == p && !wr_en)[*3];
  endsequence
  a_speedup_start: assert property ($fell(ringing) |-> ##[1:2] speedup)
    else $error("speedup late after ringing exit");
  a_speedup_cause: assert property ($rose(speedup) |-> $past(ringing, 2) || $past(ringing, 3))
    else $error("speedup without ringing exit");
  a_battery_refresh: assert property (s_sense(bat_valid, 8'h0D) |=> rd_data == $past(bat_sample, 2))
    else $error("battery word stale");
  a_loop_refresh: assert property (s_sense(loop_valid, 8'h07) |=> rd_data == $past(loop_sample, 2))
    else $error("loop word stale");
  a_write_readback: assert property (wr_en && rd_hit && quiet ##1 rd_en && !wr_en && quiet
    && addr == $past(addr) |=> rd_data == (($past(addr, 2) inside {8'h00, 8'h01, 8'h04})
    ? {1'b0, $past(wr_data[14:0], 2)} : $past(wr_data, 2))) else $error("readback wrong");
  a_reset_clear: assert property ($rose(rst_n) |-> ocv_target == 16'h0000 && !speedup)
    else $error("outputs not clear after reset");
  a_offhook_steady: assert property ((off_hook && !wr_en)[*6] |-> $stable(ocv_target))
    else $error("target moved while off hook");
  a_cm_swap: assert property (s_pol(1'b0) ##1 s_pol(1'b1) |-> ring_cm_target == $past(tip_cm_target, 3))
    else $error("common mode not moved to second lead");
  a_cm_reverse: assert property (s_pol(1'b1) |-> tip_cm_target == 15'h0000)
    else $error("first lead driven in reverse");
endmodule // dc_feed_monitor
bind dc_feed_param_ram dc_feed_monitor u_mon (.clk, .rst_n, .wr_en, .rd_en, .rd_hit, .ringing,
  .off_hook, .reverse_pol, .bat_valid, .loop_valid, .speedup, .addr, .wr_data, .rd_data,
  .bat_sample, .loop_sample, .ocv_target, .tip_cm_target, .ring_cm_target);
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int T = 10;  // Short tick keeps settling runs brief
  logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, ringing = 0, off_hook = 0, reverse_pol = 0;
  logic bat_valid = 0, loop_valid = 0, rd_hit, speedup;
  logic [7:0] addr = 0;
  logic [14:0] tip_cm_target, ring_cm_target;
  logic [15:0] wr_data = 0, bat_sample = 0, loop_sample = 0, rd_data, ocv_target, v, d, u, c;
  logic [31:0] seed = 95;
  logic [7:0] maps [7] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h07, 8'h0D, 8'hA9};
  logic [15:0] nset [3] = '{16'h0000, 16'h0001, 16'h0003};
  int num_errors = 0, n_compared = 0, len, ex;
  logic [15:0] mem [logic [7:0]];  // Word model of the bank
  dc_feed_param_ram #(.TICK_CYCLES(T)) dut (.clk, .rst_n, .addr, .wr_en, .wr_data, .rd_en, .rd_data,
    .rd_hit, .ringing, .off_hook, .reverse_pol, .bat_valid, .bat_sample, .loop_valid, .loop_sample,
    .ocv_target, .tip_cm_target, .ring_cm_target, .speedup);
  initial forever #50 clk = ~clk;
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bus tasks start and end on a rising edge
  task automatic wr(logic [7:0] a, logic [15:0] x);
    addr <= a;
    wr_data <= x;
    wr_en <= 1'b1;
    @(posedge clk) wr_en <= 1'b0;
    if (mem.exists(a)) mem[a] = (a inside {8'h00, 8'h01, 8'h04}) ? {1'b0, x[14:0]} : x;
  endtask
  task automatic rd_chk(logic [7:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk) rd_en <= 1'b0;
    @(negedge clk) cmp("rd_data", mem.exists(a) ? mem[a] : 16'h0000, rd_data);
    cmp("rd_hit", 16'(mem.exists(a)), {15'h0000, rd_hit});
    @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (maps[i]) mem[maps[i]] = 16'h0000;
    @(posedge clk);
    foreach (maps[i]) rd_chk(maps[i]);
    repeat (3) foreach (maps[i]) begin
      wr(maps[i], rnd());
      rd_chk(maps[i]);
    end
    wr(8'h02, rnd());
    rd_chk(8'h02);
    for (int k = 0; k < 4; k++) begin
      bat_valid <= 1'b1;
      loop_valid <= 1'b1;
      bat_sample <= rnd();
      loop_sample <= rnd();
      @(posedge clk) bat_valid <= 1'b0;
      loop_valid <= 1'b0;
      mem[8'h0D] = bat_sample;
      mem[8'h07] = loop_sample;
      rd_chk(k[0] ? 8'h0D : 8'h07);
      rd_chk(k[0] ? 8'h07 : 8'h0D);
    end
    foreach (nset[i]) begin
      wr(8'hA9, nset[i]);
      rd_chk(8'hA9);
      ringing <= 1'b1;
      @(posedge clk) ringing <= 1'b0;
      ex = (nset[i] == 16'h0000 ? 48 : int'(nset[i])) * T;
      len = 0;
      for (int n = 0; n < 600 && (len == 0 || speedup); n++) begin
        @(negedge clk);
        if (speedup === 1'b1) len++;
      end
      cmp("speedup_len", 16'h0001, {15'h0000, len > ex - T && len <= ex + 2});
      if (len == 0 || speedup !== 1'b0) give_verdict();
      @(posedge clk);
    end
    v = rnd() & 16'h0FFF;
    d = rnd() & 16'h0FFF;
    u = rnd() & 16'h00FF;
    wr(8'h00, v);
    rd_chk(8'h00);
    wr(8'h01, d);
    rd_chk(8'h01);
    wr(8'h03, u);
    rd_chk(8'h03);
    repeat (3) @(negedge clk);
    cmp("ocv_target", v, ocv_target);
    @(posedge clk) off_hook <= 1'b1;
    loop_valid <= 1'b1;
    loop_sample <= 16'h0000;
    @(posedge clk) loop_valid <= 1'b0;
    repeat (8) @(negedge clk);
    cmp("ocv_target", v + d, ocv_target);
    @(posedge clk) off_hook <= 1'b0;
    repeat (6) @(negedge clk);
    cmp("ocv_target", v + d, ocv_target);
    // Loop exactly at the threshold keeps the offset, one count above removes it
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) loop_valid <= 1'b1;
      loop_sample <= v + u + 16'(s);
      @(posedge clk) loop_valid <= 1'b0;
      repeat (6) @(negedge clk);
      cmp("ocv_target", (s != 0) ? v : v + d, ocv_target);
    end
    c = rnd();
    @(posedge clk);
    wr(8'h04, c);
    rd_chk(8'h04);
    repeat (3) @(negedge clk);
    cmp("tip_cm", {1'b0, c[14:0]}, {1'b0, tip_cm_target});
    @(posedge clk) reverse_pol <= 1'b1;
    repeat (5) @(negedge clk);
    cmp("ring_cm", {1'b0, c[14:0]}, {1'b0, ring_cm_target});
    cmp("tip_cm", 16'h0000, {1'b0, tip_cm_target});
    give_verdict();
  end
endmodule // tb
`default_nettype wire
